// ==== hw/zero_seq_recloser.sv ====
// zero sequence recloser control with apb registers, events and record log
// Overview of operation
// R1 - eight delay groups; active group selectable at run time, applied at once
// R2 - control word is global and unaffected by group switching
// R3 - enable low asserts blocked output and suppresses close command
// R4 - a rising trip input starts the reclosing sequence
// R5 - reclose delay up to 1800 s in 5 ms steps
// R6 - countdown advances only while protection-blocked input is held
// R7 - close command asserts after trip once delay fully elapsed
// R8 - active output set on trip, held until fault clears
// R9 - protection-block output held from blocked input until fault clears
// R10 - protection must use our block output and feed trip/blocked to us
// R11 - feeders use staggered trip delays; no relay communication
// R12 - after reclosing onto fault both stay blocked until cleared
// R13 - global forcing of status to five values, normal by default
// R14 - condition reported as one of six states
// R15 - on and off events for five signals; on/off selectable
// R16 - every event carries a time stamp; only the close and blocked on-edge records hold one, the status bits do not
// R17 - twelve most recent records kept, oldest discarded
// R18 - close or blocked rising edge stores a record
// R19 - blocked input dropping early abandons countdown; restart on next assert
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module zero_seq_recloser #(
	parameter int STEP_CYC = zsr_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protection side
	input wire logic enable_in,
	input wire logic neutral_ov_trip_ind,
	input wire logic neutral_ov_blocked_ind,
	// outputs
	output logic recloser_disabled_out,
	output logic sequence_active_out,
	output logic breaker_close_cmd,
	output logic protection_block_out,
	output logic irq
);
	localparam int DW = zsr_pkg::DELAY_W;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT,
		SEQ_COUNT,
		SEQ_CLOSED
	} seq_t;

	// registers
	logic [31:0] ctrl_ff;
	logic [2:0] group_ff;
	logic [DW-1:0] delay_ff [zsr_pkg::NUM_GROUPS];
	logic [zsr_pkg::NUM_EVT-1:0] irq_stat_ff;
	logic [zsr_pkg::NUM_EVT-1:0] irq_en_ff;
	logic [3:0] log_sel_ff;
	seq_t seq_ff;
	logic [DW-1:0] remain_ff;
	logic [31:0] presc_ff;
	logic [31:0] stamp_ff;
	logic trip_d_ff;
	logic been_active_ff;
	logic [zsr_pkg::NUM_EVT-1:0] ev_d_ff;
	zsr_pkg::log_rec_t log_ff [zsr_pkg::LOG_DEPTH];
	logic [3:0] log_wr_ff;
	logic [3:0] log_cnt_ff;
	logic [31:0] prdata_ff;
	logic rd_wait_ff;

	// apb decode
	wire logic wr_en = psel & penable & pwrite;
	wire logic rd_en = psel & penable & ~pwrite;
	wire logic is_delay = paddr >= zsr_pkg::OFS_DELAY_BASE && paddr < zsr_pkg::OFS_STATUS;
	wire logic [2:0] delay_idx = 3'((paddr - zsr_pkg::OFS_DELAY_BASE) >> 2);
	wire logic aligned = paddr[1:0] == 2'b00;
	wire logic known = aligned && (is_delay || paddr == zsr_pkg::OFS_CTRL
		|| paddr == zsr_pkg::OFS_GROUP || paddr == zsr_pkg::OFS_STATUS
		|| paddr == zsr_pkg::OFS_REMAIN || paddr == zsr_pkg::OFS_IRQ_STAT
		|| paddr == zsr_pkg::OFS_IRQ_CLR || paddr == zsr_pkg::OFS_IRQ_EN
		|| paddr == zsr_pkg::OFS_TSTAMP || paddr == zsr_pkg::OFS_LOG_COUNT
		|| paddr == zsr_pkg::OFS_LOG_SEL || paddr == zsr_pkg::OFS_LOG_TIME
		|| paddr == zsr_pkg::OFS_LOG_INFO || paddr == zsr_pkg::OFS_LOG_REMAIN);
	// one wait state on reads so read data can come from a flip-flop
	assign pready = ~rd_en | rd_wait_ff;
	assign pslverr = psel & penable & ~known;
	assign prdata = prdata_ff;

	// global forcing, static regardless of group
	wire logic force_en = ctrl_ff[zsr_pkg::CTRL_FORCE_EN]; // R2 R13
	wire logic [2:0] force_sel = ctrl_ff[zsr_pkg::CTRL_FORCE_LSB +: 3];
	wire logic f_block = force_en && force_sel == zsr_pkg::FORCE_BLOCK;
	wire logic f_req = force_en && force_sel == zsr_pkg::FORCE_REQUESTED;
	wire logic f_close = force_en && force_sel == zsr_pkg::FORCE_CLOSE_CMD;
	wire logic f_cblk = force_en && force_sel == zsr_pkg::FORCE_CLOSED_BLK;

	// live group value, taken each cycle so a switch applies at once
	wire logic [DW-1:0] cur_delay = delay_ff[group_ff]; // R1
	wire logic trip_rise = neutral_ov_trip_ind & ~trip_d_ff;
	wire logic tick = presc_ff == 32'(STEP_CYC - 1);
	// fault cleared: protection neither tripping nor blocked
	wire logic fault_clear = ~neutral_ov_trip_ind & ~neutral_ov_blocked_ind;

	// raw outputs before forcing; disabled and request already include it
	wire logic disabled = ~enable_in | f_block; // R3
	wire logic active_raw = seq_ff != SEQ_IDLE; // R8
	wire logic close_raw = seq_ff == SEQ_COUNT && remain_ff == '0; // R7
	wire logic pblk_raw = (seq_ff == SEQ_COUNT || seq_ff == SEQ_CLOSED)
		&& neutral_ov_blocked_ind | seq_ff == SEQ_CLOSED; // R9 R12
	wire logic request = seq_ff == SEQ_WAIT | f_req;

	assign recloser_disabled_out = disabled;
	assign sequence_active_out = active_raw;
	assign breaker_close_cmd = ~disabled & (close_raw | f_close); // R3 R7
	assign protection_block_out = pblk_raw | f_cblk | f_close;

	// condition code
	wire zsr_pkg::cond_t cond = disabled ? zsr_pkg::ST_BLOCKED :
		breaker_close_cmd ? zsr_pkg::ST_CLOSE_CMD :
		(seq_ff == SEQ_CLOSED || f_cblk) ? zsr_pkg::ST_CLOSED_BLK :
		request ? zsr_pkg::ST_REQUESTED :
		active_raw ? zsr_pkg::ST_ACTIVE : zsr_pkg::ST_NORMAL; // R14

	// events: on/off edges, filtered by selection
	wire logic [zsr_pkg::NUM_EVT-1:0] ev_now = {protection_block_out, breaker_close_cmd,
		sequence_active_out, disabled, request};
	wire logic [zsr_pkg::NUM_EVT-1:0] ev_on = ev_now & ~ev_d_ff;
	wire logic [zsr_pkg::NUM_EVT-1:0] ev_off = ~ev_now & ev_d_ff;
	wire logic [zsr_pkg::NUM_EVT-1:0] ev_keep =
		(ctrl_ff[zsr_pkg::CTRL_EVT_ON] ? ev_on : '0) |
		(ctrl_ff[zsr_pkg::CTRL_EVT_OFF] ? ev_off : '0); // R15
	wire logic [zsr_pkg::NUM_EVT-1:0] clr_mask =
		(wr_en && paddr == zsr_pkg::OFS_IRQ_CLR) ? pwdata[zsr_pkg::NUM_EVT-1:0] : '0;
	assign irq = |(irq_stat_ff & irq_en_ff);

	// record on close or blocked on-edge
	wire logic rec_close = ev_on[zsr_pkg::EV_CLOSE]; // R18
	wire logic rec_blk = ev_on[zsr_pkg::EV_BLOCKED];
	wire logic rec_we = rec_close | rec_blk;
	wire zsr_pkg::log_rec_t new_rec = '{stamp: stamp_ff, // R16
		event_code: rec_close ? 3'(zsr_pkg::EV_CLOSE) : 3'(zsr_pkg::EV_BLOCKED),
		group: group_ff, been_active: been_active_ff, remain: remain_ff};
	// log_sel 0 is newest
	wire logic [4:0] rd_slot_raw = 5'(log_wr_ff) + 5'(zsr_pkg::LOG_DEPTH) - 5'd1 - 5'(log_sel_ff);
	wire logic [3:0] rd_slot = rd_slot_raw >= 5'(zsr_pkg::LOG_DEPTH) ?
		4'(rd_slot_raw - 5'(zsr_pkg::LOG_DEPTH)) : 4'(rd_slot_raw);
	wire zsr_pkg::log_rec_t sel_rec = log_ff[rd_slot];

	// read mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = zsr_pkg::SLV_ZERO;
		if (is_delay) begin
			rd_val = 32'(delay_ff[delay_idx]);
		end else begin
			unique case (paddr)
				zsr_pkg::OFS_CTRL: rd_val = ctrl_ff;
				zsr_pkg::OFS_GROUP: rd_val = 32'(group_ff);
				zsr_pkg::OFS_STATUS: rd_val = 32'({ev_now, 1'b0, cond});
				zsr_pkg::OFS_REMAIN: rd_val = 32'(remain_ff);
				zsr_pkg::OFS_IRQ_STAT: rd_val = 32'(irq_stat_ff);
				zsr_pkg::OFS_IRQ_EN: rd_val = 32'(irq_en_ff);
				zsr_pkg::OFS_TSTAMP: rd_val = stamp_ff;
				zsr_pkg::OFS_LOG_COUNT: rd_val = 32'(log_cnt_ff);
				zsr_pkg::OFS_LOG_SEL: rd_val = 32'(log_sel_ff);
				zsr_pkg::OFS_LOG_TIME: rd_val = sel_rec.stamp;
				zsr_pkg::OFS_LOG_INFO: rd_val = 32'({sel_rec.been_active, sel_rec.group,
					1'b0, sel_rec.event_code});
				zsr_pkg::OFS_LOG_REMAIN: rd_val = 32'(sel_rec.remain);
				default: rd_val = zsr_pkg::SLV_ZERO;
			endcase
		end
	end

	// sequence next state
	seq_t nxt_seq;
	logic [DW-1:0] nxt_remain;
	always_comb begin
		nxt_seq = seq_ff;
		nxt_remain = remain_ff;
		unique case (seq_ff)
			SEQ_IDLE: begin
				if (trip_rise && enable_in) begin
					nxt_seq = SEQ_WAIT; // R4
				end
			end
			SEQ_WAIT: begin
				if (!enable_in || fault_clear) begin
					nxt_seq = SEQ_IDLE;
				end else if (neutral_ov_blocked_ind) begin
					nxt_seq = SEQ_COUNT; // R6
					nxt_remain = cur_delay;
				end
			end
			SEQ_COUNT: begin
				if (!enable_in) begin
					nxt_seq = SEQ_IDLE;
				end else if (fault_clear) begin
					nxt_seq = SEQ_IDLE; // R8
				end else if (!neutral_ov_blocked_ind && remain_ff != '0) begin
					nxt_seq = SEQ_WAIT; // R19
				end else if (remain_ff == '0) begin
					nxt_seq = SEQ_CLOSED; // R7
				end else if (remain_ff > cur_delay) begin
					nxt_remain = cur_delay; // R1
				end else if (tick) begin
					nxt_remain = remain_ff - 1'b1; // R5
				end
			end
			SEQ_CLOSED: begin
				if (fault_clear) begin
					nxt_seq = SEQ_IDLE; // R8 R12
				end
			end
		endcase
	end

	// sequence and timebase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_ff <= SEQ_IDLE;
			remain_ff <= zsr_pkg::DELAY_RESET;
			trip_d_ff <= 1'b0;
			been_active_ff <= 1'b0;
			presc_ff <= zsr_pkg::SLV_ZERO;
			stamp_ff <= zsr_pkg::SLV_ZERO;
			ev_d_ff <= '0;
		end else begin
			seq_ff <= nxt_seq;
			remain_ff <= nxt_remain;
			trip_d_ff <= neutral_ov_trip_ind;
			been_active_ff <= been_active_ff | active_raw;
			presc_ff <= tick ? zsr_pkg::SLV_ZERO : presc_ff + 1'b1;
			stamp_ff <= tick ? stamp_ff + 1'b1 : stamp_ff;
			ev_d_ff <= ev_now;
		end
	end

	// software registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= zsr_pkg::CTRL_RESET;
			group_ff <= '0;
			irq_en_ff <= '0;
			log_sel_ff <= '0;
			prdata_ff <= zsr_pkg::SLV_ZERO;
			rd_wait_ff <= 1'b0;
		end else begin
			if (wr_en && paddr == zsr_pkg::OFS_CTRL) ctrl_ff <= pwdata;
			if (wr_en && paddr == zsr_pkg::OFS_GROUP) group_ff <= pwdata[2:0]; // R1
			if (wr_en && paddr == zsr_pkg::OFS_IRQ_EN) irq_en_ff <= pwdata[zsr_pkg::NUM_EVT-1:0];
			if (wr_en && paddr == zsr_pkg::OFS_LOG_SEL && pwdata[3:0] < 4'(zsr_pkg::LOG_DEPTH)) begin
				log_sel_ff <= pwdata[3:0];
			end
			rd_wait_ff <= rd_en & ~rd_wait_ff;
			if (rd_en && !rd_wait_ff) prdata_ff <= rd_val;
		end
	end

	// sticky status: set wins over clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~clr_mask) | ev_keep; // R15
		end
	end

	// delay groups, values above the maximum are clamped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < zsr_pkg::NUM_GROUPS; i++) delay_ff[i] <= zsr_pkg::DELAY_RESET;
		end else if (wr_en && is_delay && aligned) begin
			delay_ff[delay_idx] <= pwdata[DW-1:0] > zsr_pkg::DELAY_MAX ?
				zsr_pkg::DELAY_MAX : pwdata[DW-1:0]; // R5
		end
	end

	// record ring: overwrite oldest
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			log_wr_ff <= '0;
			log_cnt_ff <= '0;
			for (int i = 0; i < zsr_pkg::LOG_DEPTH; i++) log_ff[i] <= '0;
		end else if (rec_we) begin
			log_ff[log_wr_ff] <= new_rec; // R17 R18
			log_wr_ff <= log_wr_ff == 4'(zsr_pkg::LOG_DEPTH - 1) ? 4'd0 : log_wr_ff + 1'b1;
			if (log_cnt_ff != 4'(zsr_pkg::LOG_DEPTH)) log_cnt_ff <= log_cnt_ff + 1'b1;
		end
	end
endmodule : zero_seq_recloser

// ==== hw/zsr_pkg.sv ====
// package for the zero sequence recloser control block
package zsr_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GROUP = 8'h04;
	localparam logic [7:0] OFS_DELAY_BASE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_REMAIN = 8'h2c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h34;
	localparam logic [7:0] OFS_IRQ_EN = 8'h38;
	localparam logic [7:0] OFS_TSTAMP = 8'h3c;
	localparam logic [7:0] OFS_LOG_COUNT = 8'h40;
	localparam logic [7:0] OFS_LOG_SEL = 8'h44;
	localparam logic [7:0] OFS_LOG_TIME = 8'h48;
	localparam logic [7:0] OFS_LOG_INFO = 8'h4c;
	localparam logic [7:0] OFS_LOG_REMAIN = 8'h50;

	// ctrl fields
	localparam int CTRL_FORCE_EN = 0;
	localparam int CTRL_FORCE_LSB = 1;
	localparam int CTRL_EVT_ON = 4;
	localparam int CTRL_EVT_OFF = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0030;

	// timing: one delay step is 5 ms
	localparam int CLK_HZ = 125_000_000;
	localparam int STEP_US = 5000;
	localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;
	localparam int DELAY_W = 19;
	localparam logic [DELAY_W-1:0] DELAY_MAX = 19'h57e40;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 19'h00000;

	localparam int NUM_GROUPS = 8;
	localparam int LOG_DEPTH = 12;
	localparam int NUM_EVT = 5;
	localparam logic [31:0] SLV_ZERO = 32'h0000_0000;

	// event bit positions
	localparam int EV_REQUEST = 0;
	localparam int EV_BLOCKED = 1;
	localparam int EV_ACTIVE = 2;
	localparam int EV_CLOSE = 3;
	localparam int EV_PROT_BLK = 4;

	typedef enum logic [2:0] {
		FORCE_NORMAL,
		FORCE_BLOCK,
		FORCE_REQUESTED,
		FORCE_CLOSE_CMD,
		FORCE_CLOSED_BLK
	} force_t;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_REQUESTED,
		ST_BLOCKED,
		ST_ACTIVE,
		ST_CLOSE_CMD,
		ST_CLOSED_BLK
	} cond_t;

	typedef struct packed {
		logic [31:0] stamp;
		logic [2:0] event_code;
		logic [2:0] group;
		logic been_active;
		logic [DELAY_W-1:0] remain;
	} log_rec_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage : zsr_pkg

// ==== testbench/zsr_checker.sv ====
// port assertions for the zero sequence recloser
`timescale 1ns/1ps
module zsr_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// protection side
	input wire logic enable_in,
	input wire logic neutral_ov_trip_ind,
	input wire logic neutral_ov_blocked_ind,
	input wire logic recloser_disabled_out,
	input wire logic sequence_active_out,
	input wire logic breaker_close_cmd,
	input wire logic protection_block_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	dis_shown_a: assert property (!enable_in |-> recloser_disabled_out)
		else $error("disabled output low while enable is off");
	no_close_off_a: assert property (!enable_in |-> !breaker_close_cmd)
		else $error("close while enable is off");
	abort_seq_a: assert property (!enable_in |=> !sequence_active_out)
		else $error("sequence kept while enable is off");
	active_trip_a: assert property ($rose(neutral_ov_trip_ind) && enable_in ##1 enable_in
		|-> sequence_active_out) else $error("trip did not start the sequence");
	active_clear_a: assert property (sequence_active_out && !neutral_ov_trip_ind
		&& !neutral_ov_blocked_ind |=> !sequence_active_out) else $error("active after clear");
	close_blk_a: assert property (breaker_close_cmd && sequence_active_out
		|-> $past(neutral_ov_blocked_ind)) else $error("close without blocked input");
	blk_after_close_a: assert property ($fell(breaker_close_cmd) && sequence_active_out
		&& enable_in |-> protection_block_out) else $error("no protection block after close");
	wait_no_close_a: assert property (sequence_active_out && !neutral_ov_blocked_ind
		&& !protection_block_out && !breaker_close_cmd |=> !breaker_close_cmd)
		else $error("close without a counted delay");
	ready_one_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	close_c: cover property (breaker_close_cmd && sequence_active_out);
	abort_c: cover property ($fell(sequence_active_out));
	err_c: cover property (pslverr);
endmodule : zsr_checker

// ==== testbench/zsr_far_end.sv ====
// neutral overvoltage protection and breaker around the recloser
`timescale 1ns/1ps
module zsr_far_end #(
	parameter int TRIP_DLY = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// scenario control
	input wire logic fault,
	input wire logic mask_blk,
	// recloser side
	input wire logic protection_block_out,
	input wire logic breaker_close_cmd,
	output logic neutral_ov_trip_ind,
	output logic neutral_ov_blocked_ind
);
	logic [7:0] cnt_ff;
	logic open_ff;
	logic block_in;
	assign block_in = protection_block_out | open_ff;
	// lost block input lets protection pick up again
	assign neutral_ov_trip_ind = (cnt_ff >= 8'(TRIP_DLY)) | (mask_blk & fault);
	assign neutral_ov_blocked_ind = fault & block_in & ~mask_blk;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
			open_ff <= 1'b0;
		end else begin
			cnt_ff <= (fault && !block_in) ? cnt_ff + 8'h01 : 8'h00;
			// operator recloses a healthy feeder by hand
			if (breaker_close_cmd || !fault)
				open_ff <= 1'b0;
			else if (neutral_ov_trip_ind)
				open_ff <= 1'b1;
		end
	end
endmodule : zsr_far_end

// ==== testbench/tb.sv ====
// self-checking bench for the zero sequence recloser
`timescale 1ns/1ps
module tb;
	localparam int STEP = 10;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic enable_in, trip, blk, dis, act, cls, pblk, irq, fault, mask_blk;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	zero_seq_recloser #(.STEP_CYC(STEP)) zero_seq_recloser_inst (.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_in(enable_in),
		.neutral_ov_trip_ind(trip), .neutral_ov_blocked_ind(blk),
		.recloser_disabled_out(dis), .sequence_active_out(act), .breaker_close_cmd(cls),
		.protection_block_out(pblk), .irq(irq));
	zsr_far_end zsr_far_end_inst (.sys_clk(sys_clk), .rst(rst), .fault(fault),
		.mask_blk(mask_blk), .protection_block_out(pblk), .breaker_close_cmd(cls),
		.neutral_ov_trip_ind(trip), .neutral_ov_blocked_ind(blk));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	// response and read data are taken at the edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic measure(input int steps);
		int n;
		for (n = 0; n < 500 && blk !== 1'b1; n++) @(negedge sys_clk);
		for (n = 0; n < 2000 && cls !== 1'b1; n++) @(negedge sys_clk);
		chk("close delay", 1, 32'(n >= (steps - 1) * STEP && n <= steps * STEP + 4));
		@(posedge sys_clk);
	endtask : measure
	task automatic run_seq(input int g, input logic irq_on);
		apb(1'b1, zsr_pkg::OFS_GROUP, 32'(g));
		fault <= 1'b1;
		measure(g + 2);
		chk("active", 1, act);
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk("close pulse", 0, cls);
		chk("pblk held", 1, pblk);
		chk("irq", 32'(irq_on), irq);
		apb(1'b0, zsr_pkg::OFS_LOG_INFO, 32'h0);
		chk("log info", 32'(g * 16 + 3), rd & 32'h77);
		fault <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("active clear", 0, act);
		chk("pblk clear", 0, pblk);
	endtask : run_seq
	task automatic drop_blk;
		apb(1'b1, zsr_pkg::OFS_GROUP, 32'h5);
		fault <= 1'b1;
		repeat (30) @(posedge sys_clk);
		mask_blk <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("early close", 0, cls);
		chk("active kept", 1, act);
		mask_blk <= 1'b0;
		measure(7);
		fault <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : drop_blk
	task automatic disabled;
		int n;
		enable_in <= 1'b0;
		fault <= 1'b1;
		for (n = 0; n < 200 && cls === 1'b0; n++) @(negedge sys_clk);
		chk("no close off", 200, n);
		chk("disabled out", 1, dis);
		chk("active off", 0, act);
		@(posedge sys_clk);
		fault <= 1'b0;
		enable_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : disabled
	task automatic forcing;
		logic [2:0] cond [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h5};
		logic [2:0] outs [5] = '{3'h0, 3'h4, 3'h0, 3'h3, 3'h1};
		for (int c = 0; c < 5; c++) begin
			apb(1'b1, zsr_pkg::OFS_CTRL, 32'h31 | 32'(c * 2));
			apb(1'b0, zsr_pkg::OFS_STATUS, 32'h0);
			chk("forced cond", 32'(cond[c]), 32'(rd[2:0]));
			chk("forced outs", 32'(outs[c]), 32'({dis, cls, pblk}));
		end
		apb(1'b1, zsr_pkg::OFS_CTRL, zsr_pkg::CTRL_RESET);
	endtask : forcing
	// forced close and block edges, twelve in all, fill the ring to its depth
	task automatic log_ring;
		logic [31:0] t;
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, zsr_pkg::OFS_CTRL, (i == 11) ? 32'h33 : 32'h37);
			apb(1'b1, zsr_pkg::OFS_CTRL, zsr_pkg::CTRL_RESET);
		end
		apb(1'b0, zsr_pkg::OFS_LOG_COUNT, 32'h0);
		chk("log count", 32'(zsr_pkg::LOG_DEPTH), rd);
		apb(1'b0, zsr_pkg::OFS_LOG_INFO, 32'h0);
		chk("newest event", 32'(zsr_pkg::EV_BLOCKED), rd & 32'h7);
		apb(1'b0, zsr_pkg::OFS_TSTAMP, 32'h0);
		t = rd;
		apb(1'b0, zsr_pkg::OFS_LOG_TIME, 32'h0);
		chk("log stamp", 1, 32'(rd != 0 && rd <= t));
		apb(1'b1, zsr_pkg::OFS_LOG_SEL, 32'hb);
		apb(1'b0, zsr_pkg::OFS_LOG_INFO, 32'h0);
		chk("oldest event", 32'(zsr_pkg::EV_CLOSE), rd & 32'h7);
	endtask : log_ring
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		{rst, enable_in} = 2'b11;
		{psel, penable, pwrite, paddr, pwdata, fault, mask_blk} = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		for (int g = 0; g < 8; g++) apb(1'b1, zsr_pkg::OFS_DELAY_BASE + 8'(4 * g), 32'(g + 2));
		apb(1'b1, zsr_pkg::OFS_GROUP, 32'h7);
		apb(1'b0, zsr_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", zsr_pkg::CTRL_RESET, rd);
		apb(1'b0, 8'h7c, 32'h0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		apb(1'b1, zsr_pkg::OFS_IRQ_EN, 32'h8);
		run_seq(3, 1'b1);
		apb(1'b1, zsr_pkg::OFS_IRQ_CLR, 32'h1f);
		@(posedge sys_clk);
		chk("irq cleared", 0, irq);
		apb(1'b1, zsr_pkg::OFS_IRQ_EN, 32'h0);
		run_seq(5, 1'b0);
		apb(1'b0, zsr_pkg::OFS_IRQ_STAT, 32'h0);
		chk("irq stat", 32'h8, rd & 32'h8);
		drop_blk();
		disabled();
		forcing();
		log_ring();
		summarize();
	end
endmodule : tb
bind zero_seq_recloser zsr_checker zsr_checker_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .enable_in(enable_in),
	.neutral_ov_trip_ind(neutral_ov_trip_ind), .neutral_ov_blocked_ind(neutral_ov_blocked_ind),
	.recloser_disabled_out(recloser_disabled_out), .sequence_active_out(sequence_active_out),
	.breaker_close_cmd(breaker_close_cmd), .protection_block_out(protection_block_out));
